// ### hdl/dtid_pkg.sv
package dtid_pkg;

  localparam int IR_W     = 5;
  localparam int VCMD_W   = 8;
  localparam int DBG_W    = 32;
  localparam int DR_MAX   = 97;
  localparam int ST_W     = 5;

  localparam logic [IR_W-1:0] OP_PINS_FLOAT = 5'h00;
  localparam logic [IR_W-1:0] OP_IDENT      = 5'h01;
  localparam logic [IR_W-1:0] OP_SAMPLE     = 5'h02;
  localparam logic [IR_W-1:0] OP_IMPL       = 5'h03;
  localparam logic [IR_W-1:0] OP_SW_VENDOR  = 5'h04;
  localparam logic [IR_W-1:0] OP_SW_DEBUG   = 5'h05;
  localparam logic [IR_W-1:0] OP_EXT_TEST   = 5'h06;
  localparam logic [IR_W-1:0] OP_VCMD       = 5'h07;
  localparam logic [IR_W-1:0] OP_ADDR       = 5'h08;
  localparam logic [IR_W-1:0] OP_DATA       = 5'h09;
  localparam logic [IR_W-1:0] OP_CTRL       = 5'h0a;
  localparam logic [IR_W-1:0] OP_ALL        = 5'h0b;
  localparam logic [IR_W-1:0] OP_DBOOT      = 5'h0c;
  localparam logic [IR_W-1:0] OP_NBOOT      = 5'h0d;
  localparam logic [IR_W-1:0] OP_QDATA      = 5'h0e;
  localparam logic [IR_W-1:0] OP_BYPASS     = 5'h1f;
  localparam logic [IR_W-1:0] IR_RESET      = OP_IDENT;
  localparam logic [IR_W-1:0] IR_CAPTURE    = 5'h01;

  localparam logic [VCMD_W-1:0] CMD_STATUS     = 8'h00;
  localparam logic [VCMD_W-1:0] CMD_RST_ASSERT = 8'h01;
  localparam logic [VCMD_W-1:0] CMD_RST_FREE   = 8'h0d;
  localparam logic [VCMD_W-1:0] CMD_ERASE      = 8'hfc;
  localparam logic [VCMD_W-1:0] CMD_FLASH_ON   = 8'hfe;
  localparam logic [VCMD_W-1:0] CMD_FLASH_OFF  = 8'hfd;
  localparam logic [VCMD_W-1:0] CMD_CFG_RELOAD = 8'hff;

  localparam logic [6:0] LEN_ONE  = 7'h01;
  localparam logic [6:0] LEN_VCMD = 7'h08;
  localparam logic [6:0] LEN_WORD = 7'h20;
  localparam logic [6:0] LEN_QD   = 7'h21;
  localparam logic [6:0] LEN_ALL  = 7'h60;

  localparam int ST_RESET_HELD = 0;
  localparam int ST_FLASH_ON   = 1;
  localparam int ST_ERASE_BUSY = 2;
  localparam int ST_WDT_FLAG   = 3;
  localparam int ST_PROG_BUSY  = 4;

  localparam logic RST_REQ_RESET   = 1'h0;
  localparam logic FLASH_REQ_RESET = 1'h1;

  localparam int CLK_PERIOD_NS = 100;
  localparam int ERASE_TIME_NS = 20000;
  localparam int PROG_TIME_NS  = 5000;
  localparam logic [7:0] ERASE_CYCLES = 8'((ERASE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] PROG_CYCLES  = 8'((PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic [1:0] {
    TAP_VENDOR = 2'h1,
    TAP_DEBUG  = 2'h2
  } dtid_tap_t;

  typedef enum logic [10:0] {
    DR_BYPASS   = 11'h001,
    DR_IDENT    = 11'h002,
    DR_BOUNDARY = 11'h004,
    DR_VCMD     = 11'h008,
    DR_IMPL     = 11'h010,
    DR_ADDR     = 11'h020,
    DR_DATA     = 11'h040,
    DR_CTRL     = 11'h080,
    DR_ALL      = 11'h100,
    DR_BOOT     = 11'h200,
    DR_QDATA    = 11'h400
  } dtid_dr_t;

endpackage : dtid_pkg

// ### hdl/dtid_top.sv
// Functional notes
// - opcode 0x1F puts the one-bit bypass stage between tdi and tdo.
// - opcode 0x00 in the vendor port floats every pin as input.
// - opcode 0x01 connects the identification word and shifts it out.
// - vendor opcode 0x02 lets the boundary chain sample pins or preload output latches.
// - vendor opcode 0x07 routes data scans to the 8-bit command register.
// - opcodes 0x04 and 0x05 select vendor or debug port, from either port.
// - command 0x00 does nothing and returns the status word.
// - command 0x01 asserts and holds the device-wide reset.
// - command 0x0D releases the device-wide reset held by command 0x01.
// - command 0xFC starts a whole-chip erase.
// - command 0xFE allows processor flash access, 0xFD blocks it.
// - command 0xFF reloads configuration from nonvolatile storage and reinitialises.
// - debug opcodes 0x08, 0x09, 0x0A select 32-bit address, data, control.
// - debug opcode 0x0B chains address, data and control into 96 bits.
// - debug opcode 0x0C forces a debug exception after boot; one-bit register.
// - debug opcode 0x0D cancels forced debug boot; one-bit register.
// - debug opcode 0x0E selects data plus the one-bit fast data register.
// - debug opcode 0x1F selects bypass, 0x01 the 32-bit identification.
// - master reset pin ends the debug session and serial programming mode.
// - a watchdog reset during a debug session returns to the vendor port.
// - watchdog lets erase finish and sets its flag; it aborts programming.
// - instruction register is 5 bits, lsb first, decoded on update.
// - vendor opcode 0x06 drives boundary patterns to pins and captures input pins.
// - command register is 8 bits, between tdi and tdo for opcode 0x07.
module dtid_top
  import dtid_pkg::*;
#(
  parameter logic [31:0] IDENT_VALUE = 32'h0a5a_5001, // arbitrary value
  parameter logic [31:0] IMPL_VALUE  = 32'h0000_0000  // arbitrary value
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        tck,
  input  wire logic        tdi,
  input  wire logic        tap_test_reset,
  input  wire logic        capture_ir,
  input  wire logic        shift_ir,
  input  wire logic        update_ir,
  input  wire logic        capture_dr,
  input  wire logic        shift_dr,
  input  wire logic        update_dr,
  input  wire logic        bsr_tdo,
  input  wire logic        master_reset_pin_n,
  input  wire logic        watchdog_reset,
  input  wire logic        serial_prog_enter,
  input  wire logic        prog_start,
  input  wire logic        wdt_flag_clear,
  output logic             tdo,
  output logic             tdo_oe_n,
  output logic             pins_float,
  output logic             bsr_select,
  output logic             bsr_external_pin_test_instr_mode,
  output dtid_tap_t        tap,
  output logic [DBG_W-1:0] debug_addr,
  output logic [DBG_W-1:0] debug_data,
  output logic [DBG_W-1:0] debug_ctrl,
  output logic             fast_data,
  output logic             debug_boot,
  output logic             sys_reset_hold,
  output logic             flash_access_en,
  output logic             erase_busy,
  output logic             config_reload,
  output logic             wdt_event_flag,
  output logic             prog_busy,
  output logic             prog_abort,
  output logic             serial_prog_mode
);

  function automatic dtid_dr_t dr_decode_f(input logic [IR_W-1:0] op, input dtid_tap_t t);
    dtid_dr_t d;
    d = DR_BYPASS;
    if (op == OP_IDENT) begin
      d = DR_IDENT;
    end else if (t == TAP_VENDOR) begin
      case (op)
        OP_SAMPLE, OP_EXT_TEST: d = DR_BOUNDARY;
        OP_VCMD:                d = DR_VCMD;
        default:                d = DR_BYPASS;
      endcase
    end else begin
      case (op)
        OP_IMPL:          d = DR_IMPL;
        OP_ADDR:          d = DR_ADDR;
        OP_DATA:          d = DR_DATA;
        OP_CTRL:          d = DR_CTRL;
        OP_ALL:           d = DR_ALL;
        OP_DBOOT, OP_NBOOT: d = DR_BOOT;
        OP_QDATA:         d = DR_QDATA;
        default:          d = DR_BYPASS;
      endcase
    end
    return d;
  endfunction : dr_decode_f

  function automatic logic [6:0] dr_len_f(input dtid_dr_t d);
    logic [6:0] n;
    n = LEN_ONE;
    case (d)
      DR_IDENT, DR_IMPL, DR_ADDR, DR_DATA, DR_CTRL: n = LEN_WORD;
      DR_VCMD:  n = LEN_VCMD;
      DR_ALL:   n = LEN_ALL;
      DR_QDATA: n = LEN_QD;
      default:  n = LEN_ONE;
    endcase
    return n;
  endfunction : dr_len_f

  // crossing flops
  logic                mr_s1, mr_s2;
  logic                mt_s1, mt_s2;
  logic                wdt_tgl, wt_s1, wt_s2, wt_s3;
  logic [ST_W-1:0]     st_s1, st_s2;
  logic                rh_s1, rh_s2, fl_s1, fl_s2;
  logic                ec_s1, ec_s2, ec_s3, cc_s1, cc_s2, cc_s3;

  // link-side state
  logic [IR_W-1:0]     ir_shift, next_ir_shift;
  logic [IR_W-1:0]     ir, next_ir;
  dtid_tap_t           next_tap;
  dtid_dr_t            dr_sel, next_dr_sel;
  logic [DR_MAX-1:0]   dr_sr, next_dr_sr, sh;
  logic [6:0]          len;
  logic [DBG_W-1:0]    next_addr, next_data, next_ctrl;
  logic                next_fast, next_boot, next_pins_float, next_bsr_select, next_external_pin_test_instr;
  logic                rst_req, next_rst_req, flash_req, next_flash_req;
  logic                erase_tgl, next_erase_tgl, cfg_tgl, next_cfg_tgl;
  logic                next_tdo, next_tdo_oe_n;
  logic                wdt_edge, mrst_t;

  // system-side state
  logic [7:0]          erase_cnt, next_erase_cnt, prog_cnt, next_prog_cnt;
  logic                next_erase_busy, next_prog_busy, next_prog_abort;
  logic                next_wdt_flag, next_cfg_reload, next_serial;
  logic                erase_start, cfg_pulse, mrst_c;

  assign wdt_edge    = wt_s2 ^ wt_s3;
  assign mrst_t      = mt_s2;
  assign mrst_c      = ~mr_s2;
  assign erase_start = ec_s2 ^ ec_s3;
  assign cfg_pulse   = cc_s2 ^ cc_s3;
  assign sys_reset_hold  = rh_s2;
  assign flash_access_en = fl_s2;

  // link clock may stop between scans, so events ride on toggles
  always_ff @(posedge tck or negedge resetn) begin
    if (!resetn) begin
      mt_s1 <= 1'h0;
      mt_s2 <= 1'h0;
      wt_s1 <= 1'h0;
      wt_s2 <= 1'h0;
      wt_s3 <= 1'h0;
      st_s1 <= '0;
      st_s2 <= '0;
    end else begin
      mt_s1 <= mrst_c;
      mt_s2 <= mt_s1;
      wt_s1 <= wdt_tgl;
      wt_s2 <= wt_s1;
      wt_s3 <= wt_s2;
      st_s1 <= {prog_busy, wdt_event_flag, erase_busy, fl_s2, rh_s2};
      st_s2 <= st_s1;
    end
  end

  always_comb begin
    next_ir_shift  = ir_shift;
    next_ir        = ir;
    next_tap       = tap;
    next_dr_sr     = dr_sr;
    next_addr      = debug_addr;
    next_data      = debug_data;
    next_ctrl      = debug_ctrl;
    next_fast      = fast_data;
    next_boot      = debug_boot;
    next_rst_req   = rst_req;
    next_flash_req = flash_req;
    next_erase_tgl = erase_tgl;
    next_cfg_tgl   = cfg_tgl;
    sh             = {1'h0, dr_sr[DR_MAX-1:1]};
    len            = dr_len_f(dr_sel);
    if (capture_ir) begin
      next_ir_shift = IR_CAPTURE;
    end else if (shift_ir) begin
      next_ir_shift = {tdi, ir_shift[IR_W-1:1]};
    end
    if (tap_test_reset) begin
      next_ir = IR_RESET;
    end else if (update_ir) begin
      next_ir = ir_shift;
      if (ir_shift == OP_SW_VENDOR) begin
        next_tap = TAP_VENDOR;
      end else if (ir_shift == OP_SW_DEBUG) begin
        next_tap = TAP_DEBUG;
      end
      if (tap == TAP_DEBUG && ir_shift == OP_DBOOT) begin
        next_boot = 1'h1;
      end else if (tap == TAP_DEBUG && ir_shift == OP_NBOOT) begin
        next_boot = 1'h0;
      end
    end
    if (wdt_edge || mrst_t) begin
      next_tap = TAP_VENDOR;
    end
    // bypass is the default of the decode
    next_dr_sel     = dr_decode_f(next_ir, next_tap);
    next_pins_float = (next_tap == TAP_VENDOR) && (next_ir == OP_PINS_FLOAT);
    next_bsr_select = (next_dr_sel == DR_BOUNDARY);
    next_external_pin_test_instr     = (next_tap == TAP_VENDOR) && (next_ir == OP_EXT_TEST);
    if (capture_dr) begin
      next_dr_sr = '0;
      case (dr_sel)
        DR_IDENT:  next_dr_sr[31:0] = IDENT_VALUE;
        DR_VCMD:   next_dr_sr[ST_W-1:0] = st_s2;
        DR_IMPL:   next_dr_sr[31:0] = IMPL_VALUE;
        DR_ADDR:   next_dr_sr[31:0] = debug_addr;
        DR_DATA:   next_dr_sr[31:0] = debug_data;
        DR_CTRL:   next_dr_sr[31:0] = debug_ctrl;
        DR_ALL:    next_dr_sr[95:0] = {debug_addr, debug_data, debug_ctrl};
        DR_BOOT:   next_dr_sr[0] = debug_boot;
        DR_QDATA:  next_dr_sr[32:0] = {debug_data, fast_data};
        default:   next_dr_sr = '0;
      endcase
    end else if (shift_dr) begin
      // variable length chain: tdi enters at the top bit of the selected length
      for (int i = 0; i < DR_MAX; i++) begin
        if (7'(i) == len - 7'h01) begin
          next_dr_sr[i] = tdi;
        end else if (7'(i) < len - 7'h01) begin
          next_dr_sr[i] = sh[i];
        end else begin
          next_dr_sr[i] = 1'h0;
        end
      end
    end else if (update_dr) begin
      case (dr_sel)
        DR_VCMD: begin
          case (dr_sr[VCMD_W-1:0])
            CMD_RST_ASSERT: next_rst_req   = 1'h1;
            CMD_RST_FREE:   next_rst_req   = 1'h0;
            CMD_ERASE:      next_erase_tgl = ~erase_tgl;
            CMD_FLASH_ON:   next_flash_req = 1'h1;
            CMD_FLASH_OFF:  next_flash_req = 1'h0;
            CMD_CFG_RELOAD: next_cfg_tgl   = ~cfg_tgl;
            default:        next_rst_req   = rst_req;
          endcase
        end
        DR_ADDR:  next_addr = dr_sr[31:0];
        DR_DATA:  next_data = dr_sr[31:0];
        DR_CTRL:  next_ctrl = dr_sr[31:0];
        DR_ALL: begin
          next_ctrl = dr_sr[31:0];
          next_data = dr_sr[63:32];
          next_addr = dr_sr[95:64];
        end
        DR_QDATA: begin
          next_fast = dr_sr[0];
          next_data = dr_sr[32:1];
        end
        default:  next_fast = fast_data;
      endcase
    end
  end

  always_ff @(posedge tck or negedge resetn) begin
    if (!resetn) begin
      ir_shift        <= IR_CAPTURE;
      ir              <= IR_RESET;
      tap             <= TAP_VENDOR;
      dr_sel          <= DR_IDENT;
      dr_sr           <= '0;
      debug_addr      <= '0;
      debug_data      <= '0;
      debug_ctrl      <= '0;
      fast_data       <= 1'h0;
      debug_boot      <= 1'h0;
      pins_float      <= 1'h0;
      bsr_select      <= 1'h0;
      bsr_external_pin_test_instr_mode <= 1'h0;
      rst_req         <= RST_REQ_RESET;
      flash_req       <= FLASH_REQ_RESET;
      erase_tgl       <= 1'h0;
      cfg_tgl         <= 1'h0;
    end else begin
      ir_shift        <= next_ir_shift;
      ir              <= next_ir;
      tap             <= next_tap;
      dr_sel          <= next_dr_sel;
      dr_sr           <= next_dr_sr;
      debug_addr      <= next_addr;
      debug_data      <= next_data;
      debug_ctrl      <= next_ctrl;
      fast_data       <= next_fast;
      debug_boot      <= next_boot;
      pins_float      <= next_pins_float;
      bsr_select      <= next_bsr_select;
      bsr_external_pin_test_instr_mode <= next_external_pin_test_instr;
      rst_req         <= next_rst_req;
      flash_req       <= next_flash_req;
      erase_tgl       <= next_erase_tgl;
      cfg_tgl         <= next_cfg_tgl;
    end
  end

  // tdo launches on the falling edge so the tester samples it on the rising one
  always_comb begin
    next_tdo_oe_n = ~(shift_ir | shift_dr);
    if (shift_ir) begin
      next_tdo = ir_shift[0];
    end else if (bsr_select) begin
      next_tdo = bsr_tdo;
    end else begin
      next_tdo = dr_sr[0];
    end
  end

  always_ff @(negedge tck or negedge resetn) begin
    if (!resetn) begin
      tdo      <= 1'h0;
      tdo_oe_n <= 1'h1;
    end else begin
      tdo      <= next_tdo;
      tdo_oe_n <= next_tdo_oe_n;
    end
  end

  // system clock side
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mr_s1 <= 1'h1;
      mr_s2 <= 1'h1;
      rh_s1 <= RST_REQ_RESET;
      rh_s2 <= RST_REQ_RESET;
      fl_s1 <= FLASH_REQ_RESET;
      fl_s2 <= FLASH_REQ_RESET;
      ec_s1 <= 1'h0;
      ec_s2 <= 1'h0;
      ec_s3 <= 1'h0;
      cc_s1 <= 1'h0;
      cc_s2 <= 1'h0;
      cc_s3 <= 1'h0;
    end else begin
      mr_s1 <= master_reset_pin_n;
      mr_s2 <= mr_s1;
      rh_s1 <= rst_req;
      rh_s2 <= rh_s1;
      fl_s1 <= flash_req;
      fl_s2 <= fl_s1;
      ec_s1 <= erase_tgl;
      ec_s2 <= ec_s1;
      ec_s3 <= ec_s2;
      cc_s1 <= cfg_tgl;
      cc_s2 <= cc_s1;
      cc_s3 <= cc_s2;
    end
  end

  always_comb begin
    next_erase_busy = erase_busy;
    next_erase_cnt  = erase_cnt;
    next_prog_busy  = prog_busy;
    next_prog_cnt   = prog_cnt;
    next_prog_abort = 1'h0;
    next_wdt_flag   = wdt_event_flag;
    next_serial     = serial_prog_mode;
    next_cfg_reload = cfg_pulse;
    // erase ignores the watchdog on purpose; a new erase started while one is busy is dropped
    if (!erase_busy && erase_start) begin
      next_erase_busy = 1'h1;
      next_erase_cnt  = ERASE_CYCLES;
    end else if (erase_busy) begin
      next_erase_cnt  = erase_cnt - 8'h01;
      next_erase_busy = (erase_cnt != 8'h01);
    end
    if (prog_busy && watchdog_reset) begin
      next_prog_busy  = 1'h0;
      next_prog_cnt   = 8'h00;
      next_prog_abort = 1'h1;
    end else if (prog_busy) begin
      next_prog_cnt  = prog_cnt - 8'h01;
      next_prog_busy = (prog_cnt != 8'h01);
    end else if (prog_start && !erase_busy) begin
      next_prog_busy = 1'h1;
      next_prog_cnt  = PROG_CYCLES;
    end
    if (wdt_flag_clear) begin
      next_wdt_flag = 1'h0;
    end
    if (watchdog_reset) begin
      next_wdt_flag = 1'h1;
    end
    if (serial_prog_enter) begin
      next_serial = 1'h1;
    end
    if (mrst_c) begin
      next_serial = 1'h0;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      erase_busy       <= 1'h0;
      erase_cnt        <= 8'h00;
      prog_busy        <= 1'h0;
      prog_cnt         <= 8'h00;
      prog_abort       <= 1'h0;
      wdt_event_flag   <= 1'h0;
      config_reload    <= 1'h0;
      serial_prog_mode <= 1'h0;
      wdt_tgl          <= 1'h0;
    end else begin
      erase_busy       <= next_erase_busy;
      erase_cnt        <= next_erase_cnt;
      prog_busy        <= next_prog_busy;
      prog_cnt         <= next_prog_cnt;
      prog_abort       <= next_prog_abort;
      wdt_event_flag   <= next_wdt_flag;
      config_reload    <= next_cfg_reload;
      serial_prog_mode <= next_serial;
      wdt_tgl          <= wdt_tgl ^ watchdog_reset;
    end
  end

  sequence ir_load_s(logic [IR_W-1:0] op);
    update_ir && !tap_test_reset && !wdt_edge && !mrst_t && ir_shift == op;
  endsequence

  sequence cmd_upd_s(logic [VCMD_W-1:0] c);
    update_dr && dr_sel == DR_VCMD && dr_sr[VCMD_W-1:0] == c;
  endsequence

  bypass_capture_a: assert property (@(posedge tck) disable iff (!resetn)
    capture_dr && dr_sel == DR_BYPASS |=> dr_sr[0] == 1'h0)
    else $error("bypass stage not cleared on capture");
  pins_float_a: assert property (@(posedge tck) disable iff (!resetn)
    ir_load_s(OP_PINS_FLOAT) ##0 tap == TAP_VENDOR |=> pins_float && dr_sel == DR_BYPASS)
    else $error("pins not floated");
  ident_capture_a: assert property (@(posedge tck) disable iff (!resetn)
    capture_dr && dr_sel == DR_IDENT |=> dr_sr[31:0] == IDENT_VALUE)
    else $error("identification word not captured");
  external_pin_test_instr_mode_a: assert property (@(posedge tck) disable iff (!resetn)
    ir_load_s(OP_EXT_TEST) ##0 tap == TAP_VENDOR |=> bsr_external_pin_test_instr_mode && bsr_select)
    else $error("external test not selected");
  vcmd_route_a: assert property (@(posedge tck) disable iff (!resetn)
    ir_load_s(OP_VCMD) ##0 tap == TAP_VENDOR |=> dr_sel == DR_VCMD)
    else $error("command register not routed");
  tap_switch_a: assert property (@(posedge tck) disable iff (!resetn)
    ir_load_s(OP_SW_DEBUG) |=> tap == TAP_DEBUG ##0 dr_sel == DR_BYPASS)
    else $error("debug port not selected");
  reset_hold_a: assert property (@(posedge tck) disable iff (!resetn)
    cmd_upd_s(CMD_RST_ASSERT) |=> rst_req)
    else $error("reset request not held");
  flash_gate_a: assert property (@(posedge tck) disable iff (!resetn)
    cmd_upd_s(CMD_FLASH_OFF) |=> !flash_req)
    else $error("flash access not blocked");
  all_chain_a: assert property (@(posedge tck) disable iff (!resetn)
    capture_dr && dr_sel == DR_ALL |=>
      dr_sr[95:0] == {$past(debug_addr), $past(debug_data), $past(debug_ctrl)})
    else $error("96-bit chain capture wrong");
  ir_shift_a: assert property (@(posedge tck) disable iff (!resetn)
    shift_ir && !capture_ir |=> ir_shift[IR_W-1] == $past(tdi))
    else $error("instruction bit not shifted in");
  wdt_tap_a: assert property (@(posedge tck) disable iff (!resetn)
    wdt_edge |=> tap == TAP_VENDOR)
    else $error("watchdog did not restore vendor port");
  erase_survive_a: assert property (@(posedge clk) disable iff (!resetn)
    erase_busy && erase_cnt > 8'h01 && watchdog_reset |=> erase_busy && wdt_event_flag)
    else $error("erase disturbed by watchdog");
  prog_abort_a: assert property (@(posedge clk) disable iff (!resetn)
    prog_busy && watchdog_reset |=> !prog_busy && prog_abort ##1 !prog_abort)
    else $error("programming not aborted");
  master_reset_pin_exit_a: assert property (@(posedge clk) disable iff (!resetn)
    mrst_c |=> !serial_prog_mode)
    else $error("serial programming survived master reset");

endmodule : dtid_top

// ### test/dtid_tester.sv
module dtid_tester (
  output logic      tck,
  output logic      tdi,
  output logic      tap_test_reset,
  output logic      capture_ir,
  output logic      shift_ir,
  output logic      update_ir,
  output logic      capture_dr,
  output logic      shift_dr,
  output logic      update_dr,
  output logic      bsr_tdo,
  input  wire logic tdo,
  input  wire logic tdo_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] lvl = '0;
  int         oe_err = 0;
  assign {tap_test_reset, capture_ir, shift_ir, update_ir, capture_dr, shift_dr, update_dr} = lvl;
  initial begin
    tck = 1'b1;
    tdi = 1'b0;
    bsr_tdo = 1'b0;
  end
  // tck rests high between frames; levels move just after a rise, as a real state machine would
  task automatic cyc(input logic [6:0] lv, input logic d, output logic q);
    #1 lvl = lv;
    tdi = (lv[4] | lv[1]) ? d : ~tdi;
    bsr_tdo = ~bsr_tdo;
    #14 tck = 1'b0;
    #15 q = tdo;
    if (tdo_oe_n !== !(lv[4] | lv[1]))
      oe_err++;
    tck = 1'b1;
  endtask : cyc
  task automatic scan(input logic ir, input int n, input logic [95:0] din, output logic [95:0] dout);
    logic q;
    dout = '0;
    // select states first: status synchronisers need tck rises before capture
    repeat (2) cyc(7'h00, 1'b0, q);
    cyc(ir ? 7'h20 : 7'h04, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      cyc(ir ? 7'h10 : 7'h02, din[i], q);
      dout[i] = q;
    end
    cyc(ir ? 7'h08 : 7'h01, 1'b0, q);
    cyc(7'h00, 1'b0, q);
  endtask : scan
endmodule : dtid_tester

// ### test/dtid_top_bench.sv
module dtid_top_bench
  import dtid_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] ID = 32'h1357_9bdf; // arbitrary value
  localparam logic [31:0] IM = 32'h2468_ace0; // arbitrary value
  logic             clk = 1'b0, resetn = 1'b0, master_reset_pin_n = 1'b1, watchdog_reset = 1'b0;
  logic             serial_prog_enter = 1'b0, prog_start = 1'b0, wdt_flag_clear = 1'b0;
  logic             tck, tdi, tap_test_reset, capture_ir, shift_ir, update_ir, capture_dr, shift_dr, update_dr;
  logic             bsr_tdo, tdo, tdo_oe_n, pins_float, bsr_select, bsr_external_pin_test_instr_mode, fast_data, debug_boot;
  logic             sys_reset_hold, flash_access_en, erase_busy, config_reload, wdt_event_flag, prog_busy;
  logic             prog_abort, serial_prog_mode;
  logic [DBG_W-1:0] debug_addr, debug_data, debug_ctrl;
  logic [95:0]      d;
  dtid_tap_t        tap;
  int               bad_count = 0, check_count = 0, cycles = 0, reloads = 0, aborts = 0;
  dtid_top #(.IDENT_VALUE(ID), .IMPL_VALUE(IM)) dut (.*);
  dtid_tester tester (.*);
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (config_reload === 1'b1)
      reloads++;
    if (prog_abort === 1'b1)
      aborts++;
    if (cycles == 10000) begin
      bad_count++;
      close_out();
    end
  end
  task automatic close_out();
    if (bad_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wclk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wclk
  task automatic pulse(ref logic s);
    s = 1'b1;
    wclk(1);
    s = 1'b0;
    wclk(1);
  endtask : pulse
  task automatic ir(input logic [4:0] op);
    tester.scan(1'b1, 5, 96'(op), d);
    chk(d[4:0], IR_CAPTURE);
  endtask : ir
  task automatic dr(input int n, input logic [95:0] din);
    tester.scan(1'b0, n, din, d);
  endtask : dr
  task automatic cmd(input logic [7:0] c);
    dr(8, 96'(c));
    wclk(10);
  endtask : cmd
  task automatic t_scan();
    logic [4:0] ops [4] = '{OP_BYPASS, 5'h1a, OP_ADDR, OP_QDATA};
    logic       q;
    foreach (ops[i]) begin
      ir(ops[i]);
      dr(8, 96'hb5);
      chk(d[7:0], 8'h6a);
    end
    tester.cyc(7'h40, 1'b0, q);
    dr(32, '0);
    chk(d[31:0], ID);
  endtask : t_scan
  task automatic t_pins();
    logic [4:0] ops [4] = '{OP_PINS_FLOAT, OP_SAMPLE, OP_EXT_TEST, OP_VCMD};
    logic [2:0] exp [4] = '{3'h4, 3'h2, 3'h3, 3'h0};
    foreach (ops[i]) begin
      ir(ops[i]);
      chk({pins_float, bsr_select, bsr_external_pin_test_instr_mode}, exp[i]);
      if (exp[i][1]) begin
        dr(2, '0);
        chk(d[0] ^ d[1], 1'b1);
      end
    end
  endtask : t_pins
  task automatic t_cmds();
    cmd(CMD_STATUS);
    chk(d[4:0], 5'h02);
    cmd(CMD_RST_ASSERT);
    chk(sys_reset_hold, 1'b1);
    cmd(CMD_RST_FREE);
    chk({sys_reset_hold, d[0]}, 2'b01);
    cmd(CMD_FLASH_OFF);
    chk(flash_access_en, 1'b0);
    cmd(CMD_FLASH_ON);
    chk({flash_access_en, d[1]}, 2'b10);
    cmd(CMD_CFG_RELOAD);
    chk(reloads, 1);
    cmd(CMD_ERASE);
    chk(erase_busy, 1'b1);
    pulse(watchdog_reset);
    chk({erase_busy, wdt_event_flag}, 2'b11);
    wclk(200);
    chk(erase_busy, 1'b0);
    pulse(prog_start);
    chk(prog_busy, 1'b1);
    pulse(watchdog_reset);
    chk({prog_busy, aborts[1:0]}, 3'b001);
    pulse(wdt_flag_clear);
    chk(wdt_event_flag, 1'b0);
  endtask : t_cmds
  task automatic t_debug();
    ir(OP_SW_DEBUG);
    chk(tap, TAP_DEBUG);
    ir(OP_IMPL);
    dr(32, '0);
    chk(d[31:0], IM);
    ir(OP_ADDR);
    dr(32, 96'h1234_5678);
    chk(debug_addr, 32'h1234_5678);
    ir(OP_ALL);
    dr(96, 96'h0a0b0c0d_11223344_55667788);
    chk({debug_addr, debug_data, debug_ctrl}, 96'h0a0b0c0d_11223344_55667788);
    ir(OP_QDATA);
    dr(33, 96'h1_0eca_8643);
    chk({debug_data, fast_data}, 33'h1_0eca_8643);
    ir(OP_DBOOT);
    chk(debug_boot, 1'b1);
    ir(OP_NBOOT);
    chk(debug_boot, 1'b0);
    ir(OP_BYPASS);
    dr(8, 96'hb5);
    chk(d[7:0], 8'h6a);
    ir(OP_IDENT);
    dr(32, '0);
    chk(d[31:0], ID);
    ir(OP_SW_VENDOR);
    chk(tap, TAP_VENDOR);
  endtask : t_debug
  task automatic t_resets();
    ir(OP_SW_DEBUG);
    wclk(1);
    pulse(watchdog_reset);
    dr(8, '0);
    chk(tap, TAP_VENDOR);
    ir(OP_SW_DEBUG);
    wclk(1);
    pulse(serial_prog_enter);
    chk(serial_prog_mode, 1'b1);
    master_reset_pin_n = 1'b0;
    wclk(4);
    dr(8, '0);
    chk({tap, serial_prog_mode}, {TAP_VENDOR, 1'b0});
    master_reset_pin_n = 1'b1;
  endtask : t_resets
  initial begin
    wclk(12);
    resetn = 1'b1;
    wclk(2);
    t_scan();
    t_pins();
    t_cmds();
    t_debug();
    t_resets();
    chk(tester.oe_err, 0);
    close_out();
  end
endmodule : dtid_top_bench
